// >>> hdl/tsense_pkg.sv
/*
  Constants for the temperature sensor command sequencer: address code,
  command codes, configuration layout and reset values.
  Assumes a single 125 MHz system clock domain.
*/
package tsense_pkg;
  // ==========================================================
  // Address and commands
  localparam logic [3:0] DEV_CODE = 4'h9;
  localparam logic [7:0] CMD_START_CONV = 8'h51;
  localparam logic [7:0] CMD_STOP_CONV = 8'h22;
  localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
  localparam logic [7:0] CMD_CONFIG = 8'hAC;
  localparam logic [7:0] CMD_HIGH_SP = 8'hA1;
  localparam logic [7:0] CMD_LOW_SP = 8'hA2;
  // ==========================================================
  // Configuration fields
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_RES_LSB = 2;
  localparam int CFG_ONESHOT_BIT = 0;
  localparam int CFG_FLAG_HI_BIT = 6;
  localparam int CFG_FLAG_LO_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h8C;
  localparam logic [15:0] SP_RESET = 16'h0000;
  // ==========================================================
  // Synchroniser depth and bus states
  localparam int SYNC_STAGES = 2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_WBYTE = 4'h2,
    ST_WACK = 4'h6,
    ST_RBYTE = 4'h7,
    ST_RACK = 4'h5,
    ST_IGNORE = 4'h4
  } state_t;
endpackage

// >>> hdl/pin_sync.sv
/*
  Two flip-flop synchroniser for a group of asynchronous pins.
  Assumes inputs are levels from outside the sys_clk domain.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pin_sync

// >>> hdl/temp_sensor_command_sequencer.sv
/*
  Two-wire target front end and command interpreter for a temperature sensor.
  Assumes the conversion core outside supplies temperature and flags, and that
  the bus wires are resolved outside from the output enable (open drain).
*/
// Operation
// - Acknowledge every byte received: matching address, command, each data byte.
// - Command 51h is acknowledged and starts conversion; no data follows.
// - Command AAh, repeated START, read address: acknowledge then send temperature.
// - Temperature sent MSB byte first then LSB byte, bits MSB first.
// - Command ACh then one data byte stored as configuration and acknowledged.
// - A configuration write also clears both thermostat flags, except a flag the core sets in the same cycle.
// - Configuration 08h gives 11-bit resolution, continuous mode, active-low output.
// - Command A1h then two bytes, MSB first, stored as high setpoint.
// - Command A2h then two bytes, MSB first, stored as low setpoint.
// - Respond only to address 1001 plus matching select pin levels.
// - Command 22h lets current conversion finish, then stay idle until 51h.
`timescale 1ns/1ps
module temp_sensor_command_sequencer
  import tsense_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic select_pin_0,
  input wire logic select_pin_1,
  input wire logic select_pin_2,
  input wire logic [15:0] temp_value,
  input wire logic conv_done,
  input wire logic flag_hi_set,
  input wire logic flag_lo_set,
  output logic conv_run,
  output logic conv_stop_req,
  output logic [7:0] config_value,
  output logic [1:0] resolution,
  output logic oneshot_mode,
  output logic thermostat_polarity,
  output logic [15:0] high_setpoint,
  output logic [15:0] low_setpoint
);
  import tsense_pkg::*;

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [4:0] pins_s;
  logic scl_q, sda_q;
  pin_sync #(.WIDTH(5)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({select_pin_2, select_pin_1, select_pin_0, sda_in, scl_in}),
    .sync_out(pins_s)
  );
  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];
  wire [2:0] sel_s = pins_s[4:2];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;

  // ==========================================================
  // Byte engine state
  state_t state_q, state_d;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [7:0] cmd_q;
  logic [1:0] byte_q;
  logic [7:0] tx_q;
  logic [7:0] hi_msb_q;
  logic drive_low_q;
  logic rd_mode_q;

  wire [7:0] rx_byte = {shift_q[6:0], sda_s};
  wire addr_match = (rx_byte[7:4] == DEV_CODE) && (rx_byte[3:1] == sel_s);
  wire last_bit = (bit_q == 3'd7);
  wire rx_done = scl_rise && last_bit;
  wire in_cmd = (byte_q == 2'd0);
  // Read data: temperature or register readback, MSB byte first
  wire [15:0] rd_word = (cmd_q == CMD_READ_TEMP) ? temp_value :
    (cmd_q == CMD_HIGH_SP) ? high_setpoint :
    (cmd_q == CMD_LOW_SP) ? low_setpoint : {config_value, 8'h00};
  wire [7:0] rd_byte = (byte_q == 2'd0) ? rd_word[15:8] : rd_word[7:0];
  wire wr_byte_done = (state_q == ST_WBYTE) && rx_done && !rd_mode_q;
  wire cmd_taken = wr_byte_done && in_cmd;
  wire data_taken = wr_byte_done && !in_cmd;
  wire cfg_wr = data_taken && (cmd_q == CMD_CONFIG) && (byte_q == 2'd1);
  wire hi_wr = data_taken && (cmd_q == CMD_HIGH_SP) && (byte_q == 2'd2);
  wire lo_wr = data_taken && (cmd_q == CMD_LOW_SP) && (byte_q == 2'd2);
  wire msb_wr = data_taken && (byte_q == 2'd1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: state_d = ST_IDLE;
      ST_ADDR: begin
        if (rx_done) begin
          state_d = addr_match ? ST_AACK : ST_IGNORE;
        end
      end
      ST_AACK: begin
        if (scl_fall && !drive_low_q) begin
          state_d = ST_AACK;
        end else if (scl_fall) begin
          state_d = rd_mode_q ? ST_RBYTE : ST_WBYTE;
        end
      end
      ST_WBYTE: begin
        if (rx_done) begin
          state_d = ST_WACK;
        end
      end
      ST_WACK: begin
        if (scl_fall && drive_low_q) begin
          state_d = ST_WBYTE;
        end
      end
      ST_RBYTE: begin
        if (scl_fall && last_bit) begin
          state_d = ST_RACK;
        end
      end
      ST_RACK: begin
        // Stay until the ack slot ends so the next byte is loaded on that fall
        if (scl_rise && sda_s) begin
          state_d = ST_IGNORE;
        end else if (scl_fall) begin
          state_d = ST_RBYTE;
        end
      end
      default: state_d = ST_IGNORE;
    endcase
    if (start_cond) begin
      state_d = ST_ADDR;
    end else if (stop_cond) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_q <= 3'd0;
      cmd_q <= 8'h00;
      byte_q <= 2'd0;
      tx_q <= 8'h00;
      drive_low_q <= 1'b0;
      rd_mode_q <= 1'b0;
      hi_msb_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (start_cond) begin
        bit_q <= 3'd0;
        drive_low_q <= 1'b0;
        rd_mode_q <= 1'b0;
      end else begin
        if (scl_rise && (state_q == ST_ADDR || state_q == ST_WBYTE)) begin
          shift_q <= rx_byte;
          bit_q <= bit_q + 3'd1;
        end
        if (state_q == ST_ADDR && rx_done && addr_match) begin
          rd_mode_q <= sda_s;
          if (!sda_s) begin
            byte_q <= 2'd0;
          end else begin
            byte_q <= 2'd0;
          end
        end
        // Ack is driven from the SCL fall after the eighth bit
        if (scl_fall && (state_q == ST_AACK || state_q == ST_WACK) && !drive_low_q) begin
          drive_low_q <= 1'b1;
        end else if (scl_fall && (state_q == ST_AACK || state_q == ST_WACK)) begin
          drive_low_q <= 1'b0;
          bit_q <= 3'd0;
          if (state_q == ST_AACK && rd_mode_q) begin
            tx_q <= rd_byte;
          end
        end
        if (cmd_taken) begin
          cmd_q <= rx_byte;
          byte_q <= 2'd1;
        end else if (data_taken && byte_q != 2'd3) begin
          byte_q <= byte_q + 2'd1;
        end
        if (msb_wr) begin
          hi_msb_q <= rx_byte;
        end
        if (state_q == ST_RBYTE && scl_fall) begin
          tx_q <= {tx_q[6:0], 1'b0};
          bit_q <= bit_q + 3'd1;
        end
        if (state_q == ST_RACK && scl_rise && !sda_s) begin
          byte_q <= byte_q + 2'd1;
        end
        if (state_q == ST_RACK && scl_fall) begin
          tx_q <= rd_byte;
          bit_q <= 3'd0;
        end
      end
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_q || ((state_q == ST_RBYTE) && !tx_q[7]);

  // ==========================================================
  // Command effects and stored registers
  logic run_q, stop_q, flag_hi_q, flag_lo_q;
  logic [7:0] cfg_q;
  wire is_start = cmd_taken && (rx_byte == CMD_START_CONV);
  wire is_stop = cmd_taken && (rx_byte == CMD_STOP_CONV);
  // Other codes only select a register; unknown ones touch nothing
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      run_q <= 1'b0;
      stop_q <= 1'b0;
      cfg_q <= CFG_RESET;
      high_setpoint <= SP_RESET;
      low_setpoint <= SP_RESET;
      flag_hi_q <= 1'b0;
      flag_lo_q <= 1'b0;
    end else begin
      if (is_start) begin
        run_q <= 1'b1;
        stop_q <= 1'b0;
      end else if (is_stop && run_q) begin
        stop_q <= 1'b1;
      end else if (conv_done && (stop_q || cfg_q[CFG_ONESHOT_BIT])) begin
        run_q <= 1'b0;
        stop_q <= 1'b0;
      end
      if (cfg_wr) begin
        cfg_q <= rx_byte;
      end
      // Hardware set wins over the write clear
      flag_hi_q <= flag_hi_set | (flag_hi_q & ~cfg_wr);
      flag_lo_q <= flag_lo_set | (flag_lo_q & ~cfg_wr);
      if (hi_wr) begin
        high_setpoint <= {hi_msb_q, rx_byte};
      end
      if (lo_wr) begin
        low_setpoint <= {hi_msb_q, rx_byte};
      end
    end
  end

  assign conv_run = run_q;
  assign conv_stop_req = stop_q;
  assign config_value = {cfg_q[7], flag_hi_q, flag_lo_q, cfg_q[4:0]};
  assign resolution = cfg_q[CFG_RES_LSB +: 2];
  assign oneshot_mode = cfg_q[CFG_ONESHOT_BIT];
  assign thermostat_polarity = cfg_q[CFG_POL_BIT];
endmodule // temp_sensor_command_sequencer

// >>> verif/sequencer_asserts.sv
/*
  Port checker for the temperature sensor command sequencer.
  Assumes one sys_clk domain and a bind onto the top module.
*/
`timescale 1ns/1ps
module sequencer_asserts
  import tsense_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic conv_done,
  input wire logic flag_hi_set,
  input wire logic flag_lo_set,
  input wire logic conv_run,
  input wire logic conv_stop_req,
  input wire logic [7:0] config_value,
  input wire logic [1:0] resolution,
  input wire logic oneshot_mode,
  input wire logic thermostat_polarity,
  input wire logic [15:0] high_setpoint,
  input wire logic [15:0] low_setpoint
);
  // ==========================================
  // Bus activity, cycles since SCL last moved
  logic scl_q;
  logic [4:0] idle_q;
  always_ff @(posedge sys_clk) begin
    scl_q <= scl_in;
    if (srst) idle_q <= 5'h1F;
    else if (scl_in != scl_q) idle_q <= 5'h00;
    else if (idle_q != 5'h1F) idle_q <= idle_q + 5'h01;
  end
  wire bus_busy = idle_q < 5'h10;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_stop_done;
    conv_stop_req && conv_done;
  endsequence
  sequence s_run_off;
    ##[1:2] !conv_run;
  endsequence
  // ==========================================
  // Assertions
  a_cfg_fields: assert property (
    resolution == config_value[CFG_RES_LSB+:2] && oneshot_mode == config_value[CFG_ONESHOT_BIT]
    && thermostat_polarity == config_value[CFG_POL_BIT]) else $error("config fields wrong");
  a_reset_vals: assert property ($fell(srst) |-> config_value == CFG_RESET && !conv_run
    && !sda_oe && high_setpoint == SP_RESET && low_setpoint == SP_RESET)
    else $error("reset values wrong");
  a_flag_hi_set: assert property (
    flag_hi_set |-> ##[1:2] config_value[CFG_FLAG_HI_BIT]) else $error("high flag lost");
  a_flag_lo_set: assert property (
    flag_lo_set |-> ##[1:2] config_value[CFG_FLAG_LO_BIT]) else $error("low flag lost");
  a_sp_on_bus: assert property (
    $changed(high_setpoint) || $changed(low_setpoint) |-> bus_busy)
    else $error("setpoint changed without bus traffic");
  a_run_on_bus: assert property ($rose(conv_run) |-> bus_busy)
    else $error("conversion started without command");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 3))
    else $error("data line moved while clock high");
  a_stop_halts: assert property (s_stop_done |-> s_run_off)
    else $error("conversion kept running after stop");
endmodule // sequencer_asserts

bind temp_sensor_command_sequencer sequencer_asserts sequencer_asserts_inst (.sys_clk, .srst,
  .scl_in, .sda_oe, .conv_done, .flag_hi_set, .flag_lo_set, .conv_run, .conv_stop_req,
  .config_value, .resolution, .oneshot_mode, .thermostat_polarity, .high_setpoint,
  .low_setpoint);

// >>> verif/i2c_master_model.sv
/*
  Two-wire bus master model: makes SCL, pulls SDA low when asked.
  Assumes SDA is resolved outside with a pull-up; bit period 64 ns.
*/
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // ==========================================
  // Conditions; clock stands high when idle
  task automatic start();
    // Wait for the target to let go of its ack before raising SCL
    wt(2);
    sda_pull = 1'h0;
    wt(2);
    scl = 1'h1;
    wt(4);
    sda_pull = 1'h1;
    wt(4);
    scl = 1'h0;
  endtask
  task automatic stop();
    wt(2);
    sda_pull = 1'h1;
    wt(2);
    scl = 1'h1;
    wt(4);
    sda_pull = 1'h0;
    wt(4);
  endtask
  task automatic bit_x(input logic b, output logic r);
    wt(2);
    sda_pull = !b;
    wt(2);
    scl = 1'h1;
    wt(2);
    r = sda_line;
    wt(2);
    scl = 1'h0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'h1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, b[i]);
    bit_x(last, r);
  endtask
endmodule // i2c_master_model

// >>> verif/temp_sensor_command_sequencer_tb.sv
/*
  Self-checking bench for the temperature sensor command sequencer.
  Assumes the master model and checker are compiled before it.
*/
`timescale 1ns/1ps
module temp_sensor_command_sequencer_tb;
  import tsense_pkg::*;
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic [2:0] sel = 3'h5;
  logic [15:0] temp_value = 16'hA53C;
  logic conv_done = 1'h0;
  logic flag_hi_set = 1'h0;
  logic flag_lo_set = 1'h0;
  wire scl, pull, sda_oe, conv_run, conv_stop_req, oneshot_mode, thermostat_polarity;
  wire [1:0] resolution;
  wire [7:0] config_value;
  wire [15:0] high_setpoint, low_setpoint;
  wire sda_out_w;
  wire sda = !(pull || (sda_oe && !sda_out_w));
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 sys_clk = !sys_clk;
  i2c_master_model mst (.sys_clk, .sda_line(sda), .scl, .sda_pull(pull));
  temp_sensor_command_sequencer temp_sensor_command_sequencer_inst (.sys_clk, .srst,
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out_w), .sda_oe, .select_pin_0(sel[0]),
    .select_pin_1(sel[1]), .select_pin_2(sel[2]), .temp_value, .conv_done, .flag_hi_set,
    .flag_lo_set, .conv_run, .conv_stop_req, .config_value, .resolution, .oneshot_mode,
    .thermostat_polarity, .high_setpoint, .low_setpoint);
  // ==========================================
  // Helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic ea);
    logic a;
    mst.wbyte(b, a);
    chk("ack", {15'h0000, ea}, {15'h0000, a});
  endtask
  task automatic cmd(input logic [7:0] c);
    mst.start();
    send({DEV_CODE, sel, 1'h0}, 1'h1);
    send(c, 1'h1);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_config();
    @(negedge sys_clk);
    flag_hi_set = 1'h1;
    flag_lo_set = 1'h1;
    @(negedge sys_clk);
    flag_hi_set = 1'h0;
    flag_lo_set = 1'h0;
    repeat (3) @(negedge sys_clk);
    chk("flags", {8'h00, CFG_RESET | 8'h60}, {8'h00, config_value});
    cmd(CMD_CONFIG);
    send(8'h08, 1'h1);
    mst.stop();
    chk("cfg", 16'h0008, {8'h00, config_value});
    chk("res", 16'h0002, {14'h0000, resolution});
    chk("mode", 16'h0000, {14'h0000, oneshot_mode, thermostat_polarity});
    chk("sda_out", 16'h0000, {15'h0000, sda_out_w});
  endtask
  task automatic t_setpoints();
    cmd(CMD_HIGH_SP);
    send(8'h32, 1'h1);
    send(8'h00, 1'h1);
    cmd(CMD_LOW_SP);
    send(8'h2D, 1'h1);
    send(8'h00, 1'h1);
    cmd(CMD_START_CONV);
    mst.stop();
    chk("high", 16'h3200, high_setpoint);
    chk("low", 16'h2D00, low_setpoint);
    chk("run", 16'h0001, {15'h0000, conv_run});
  endtask
  task automatic t_stop_conv();
    cmd(CMD_STOP_CONV);
    mst.stop();
    chk("stopreq", 16'h0003, {14'h0000, conv_stop_req, conv_run});
    @(negedge sys_clk);
    conv_done = 1'h1;
    @(negedge sys_clk);
    conv_done = 1'h0;
    repeat (2) @(negedge sys_clk);
    chk("halt", 16'h0000, {15'h0000, conv_run});
  endtask
  task automatic t_read();
    logic [7:0] hi, lo;
    cmd(CMD_READ_TEMP);
    mst.start();
    send({DEV_CODE, sel, 1'h1}, 1'h1);
    mst.rbyte(1'h0, hi);
    mst.rbyte(1'h1, lo);
    mst.stop();
    chk("temp", temp_value, {hi, lo});
  endtask
  task automatic t_refuse();
    mst.start();
    send({DEV_CODE, sel ^ 3'h2, 1'h0}, 1'h0);
    send(CMD_START_CONV, 1'h0);
    mst.start();
    send({4'h8, sel, 1'h0}, 1'h0);
    cmd(8'h77);
    mst.stop();
    chk("nop", 16'h0800, {config_value, 7'h00, conv_run});
  endtask
  // ==========================================
  // Main sequence and hang guard
  initial begin
    repeat (10) @(negedge sys_clk);
    srst = 1'h0;
    repeat (6) @(negedge sys_clk);
    chk("cfg_rst", {8'h00, CFG_RESET}, {8'h00, config_value});
    t_config();
    t_setpoints();
    t_stop_conv();
    t_read();
    t_refuse();
    conclude();
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
endmodule // temp_sensor_command_sequencer_tb
